//--- hdl/tgc_pkg.sv
// constants and types shared by the timer gate control block
`default_nettype none

package tgc_pkg;

    // *******************************************************************
    // register map
    // *******************************************************************
    localparam int          TGC_ADDR_W       = 12;
    localparam logic [11:0] TGC_OFS_GATE     = 12'h000;
    localparam logic [11:0] TGC_OFS_RUN      = 12'h004;
    localparam logic [11:0] TGC_OFS_STATUS   = 12'h008;
    localparam logic [11:0] TGC_OFS_MASK     = 12'h00C;

    // *******************************************************************
    // gate control field positions and reset values
    // *******************************************************************
    localparam int          TGC_BIT_GE       = 7;
    localparam int          TGC_BIT_POL      = 6;
    localparam int          TGC_BIT_GTM      = 5;
    localparam int          TGC_BIT_SPM      = 4;
    localparam int          TGC_BIT_GO       = 3;
    localparam int          TGC_BIT_VAL      = 2;
    localparam int          TGC_SS_HI        = 1;
    localparam int          TGC_SS_LO        = 0;
    localparam logic [7:0]  TGC_GATE_RST     = 8'h00;
    localparam logic [7:0]  TGC_GATE_WMASK   = 8'hFB;
    localparam int          TGC_BIT_RUN      = 0;
    localparam int          TGC_BIT_GEVT     = 0;
    localparam logic        TGC_RUN_RST      = 1'b0;
    localparam logic        TGC_IRQ_RST      = 1'b0;

    // *******************************************************************
    // gate source selection
    // *******************************************************************
    typedef enum logic [1:0] {
        TGC_SRC_PIN   = 2'h0,
        TGC_SRC_MATCH = 2'h1,
        TGC_SRC_COMP1 = 2'h2,
        TGC_SRC_COMP2 = 2'h3
    } tgc_src_t;

endpackage : tgc_pkg

`default_nettype wire

//--- hdl/tgc_gate_if.sv
// carrier between the gate logic and its synchroniser
`default_nettype none

interface tgc_gate_if;
    logic raw;
    logic synced;
    modport src  (output raw, input  synced);
    modport sync (input  raw, output synced);
endinterface : tgc_gate_if

`default_nettype wire

//--- hdl/tgc_sync.sv
// two-flop synchroniser that brings the processed gate onto the counter clock
`default_nettype none

module tgc_sync
    import tgc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    tgc_gate_if.sync  gate
);

    typedef struct packed {
        logic stage1;
        logic stage2;
    } tgc_sync_state_t;

    tgc_sync_state_t state;
    tgc_sync_state_t next_state;

    always_comb begin
        next_state        = state;
        next_state.stage1 = gate.raw;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign gate.synced = state.stage2;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sync_delay;
        gate.raw |-> ##2 gate.synced;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("gate not synced in two cycles");

endmodule : tgc_sync

`default_nettype wire

//--- hdl/tgc_top.sv
// timer gate control block with apb register access
//
// Decided for this implementation: the register addresses and the APB register port.
`default_nettype none

module tgc_top
    import tgc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        other_reset,
    input  wire logic        gate_pin,
    input  wire logic        period_match,
    input  wire logic        comp1_synced_output,
    input  wire logic        comp2_synced_output,
    input  wire logic        count_tick,
    output logic             count_enable,
    output logic             count_inc,
    output logic             irq
);

    // *******************************************************************
    // state
    // *******************************************************************
    typedef struct packed {
        logic [7:0]  gate_ctrl;
        logic        run;
        logic        status;
        logic        mask;
        logic        pol_prev;
        logic        tff;
        logic        t_prev;
        logic        capturing;
        logic        lvl_prev;
        logic [31:0] rdata;
    } tgc_state_t;

    tgc_state_t state;
    tgc_state_t next_state;

    tgc_gate_if gif ();

    tgc_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .gate    (gif.sync)
    );

    logic       src_sig;
    logic       pol_sig;
    logic       t_out;
    logic       t_rise;
    logic       t_fall;
    logic       sp_start;
    logic       gate_final;
    logic       level;
    logic       wr_en;
    logic       setup;
    logic       mapped;
    logic [7:0] wr_byte;
    logic       gevt;

    // *******************************************************************
    // gate path
    // *******************************************************************
    always_comb begin
        unique case (tgc_src_t'(state.gate_ctrl[TGC_SS_HI:TGC_SS_LO]))
            TGC_SRC_PIN:   src_sig = gate_pin;
            TGC_SRC_MATCH: src_sig = period_match;
            TGC_SRC_COMP1: src_sig = comp1_synced_output;
            TGC_SRC_COMP2: src_sig = comp2_synced_output;
            default:       src_sig = gate_pin;
        endcase
    end

    assign pol_sig    = state.gate_ctrl[TGC_BIT_POL] ? src_sig : ~src_sig;
    assign t_out      = state.gate_ctrl[TGC_BIT_GTM] ? state.tff : pol_sig;
    assign t_rise     = t_out & ~state.t_prev;
    assign t_fall     = ~t_out & state.t_prev;
    assign sp_start   = state.gate_ctrl[TGC_BIT_GO] & t_rise & ~state.capturing;
    // single pulse passes the gate only from the armed rise to the trailing edge
    assign gate_final = state.gate_ctrl[TGC_BIT_SPM]
                      ? ((state.capturing | sp_start) & t_out) : t_out;
    assign gif.raw    = gate_final;
    assign level      = gif.synced;
    assign gevt       = state.lvl_prev & ~level;

    // *******************************************************************
    // apb decode
    // *******************************************************************
    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pwrite & mapped;
    assign wr_byte = pwdata[7:0];
    assign mapped  = (paddr == TGC_OFS_GATE) | (paddr == TGC_OFS_RUN)
                   | (paddr == TGC_OFS_STATUS) | (paddr == TGC_OFS_MASK);

    // *******************************************************************
    // next state
    // *******************************************************************
    always_comb begin
        next_state          = state;
        next_state.pol_prev = pol_sig;
        next_state.t_prev   = t_out;
        next_state.lvl_prev = level;

        if (wr_en && paddr == TGC_OFS_GATE) begin
            next_state.gate_ctrl = wr_byte & TGC_GATE_WMASK;
        end
        if (wr_en && paddr == TGC_OFS_RUN) begin
            next_state.run = wr_byte[TGC_BIT_RUN];
        end
        if (wr_en && paddr == TGC_OFS_MASK) begin
            next_state.mask = wr_byte[TGC_BIT_GEVT];
        end
        if (wr_en && paddr == TGC_OFS_STATUS && wr_byte[TGC_BIT_GEVT]) begin
            next_state.status = 1'b0;
        end
        if (gevt) begin
            next_state.status = 1'b1;
        end

        // toggle flop
        if (!state.gate_ctrl[TGC_BIT_GTM] || !state.run) begin
            next_state.tff = 1'b0;
        end else if (pol_sig && !state.pol_prev) begin
            next_state.tff = ~state.tff;
        end

        // single-pulse acquisition
        if (sp_start) begin
            next_state.capturing = 1'b1;
        end
        if (state.capturing && t_fall) begin
            next_state.capturing = 1'b0;
            if (!(wr_en && paddr == TGC_OFS_GATE)) begin
                next_state.gate_ctrl[TGC_BIT_GO] = 1'b0;
            end
        end
        if (!next_state.gate_ctrl[TGC_BIT_SPM]) begin
            next_state.gate_ctrl[TGC_BIT_GO] = 1'b0;
            next_state.capturing             = 1'b0;
        end

        // other resets clear gate logic and the run bit but keep the gate control bits
        if (other_reset) begin
            next_state.tff       = 1'b0;
            next_state.capturing = 1'b0;
            next_state.run       = TGC_RUN_RST;
        end

        next_state.rdata = '0;
        if (setup) begin
            unique case (paddr)
                TGC_OFS_GATE: begin
                    next_state.rdata[7:0]         = state.gate_ctrl;
                    next_state.rdata[TGC_BIT_VAL] = level;
                end
                TGC_OFS_RUN:    next_state.rdata[TGC_BIT_RUN]  = state.run;
                TGC_OFS_STATUS: next_state.rdata[TGC_BIT_GEVT] = state.status;
                TGC_OFS_MASK:   next_state.rdata[TGC_BIT_GEVT] = state.mask;
                default:        next_state.rdata = '0;
            endcase
        end else begin
            next_state.rdata = state.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= '0;
            state.gate_ctrl <= TGC_GATE_RST;
            state.run       <= TGC_RUN_RST;
            state.status    <= TGC_IRQ_RST;
            state.mask      <= TGC_IRQ_RST;
        end else begin
            state <= next_state;
        end
    end

    // *******************************************************************
    // outputs
    // *******************************************************************
    assign count_enable = state.run & (~state.gate_ctrl[TGC_BIT_GE] | level);
    assign count_inc    = count_tick & count_enable;
    assign prdata       = state.rdata;
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & ~mapped;
    assign irq          = state.status & state.mask;

    // *******************************************************************
    // checks
    // *******************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_gated_count;
        state.run && state.gate_ctrl[TGC_BIT_GE] |-> count_enable == level;
    endproperty
    a_gated_count: assert property (p_gated_count) else $error("gated count wrong");

    property p_free_count;
        !state.run || !state.gate_ctrl[TGC_BIT_GE] |-> count_enable == state.run;
    endproperty
    a_free_count: assert property (p_free_count) else $error("free count wrong");

    property p_polarity;
        !state.gate_ctrl[TGC_BIT_GTM] && !state.gate_ctrl[TGC_BIT_SPM]
            |-> ##2 level == $past(pol_sig, 2);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity path wrong");

    property p_tff_clear;
        !state.gate_ctrl[TGC_BIT_GTM] || !state.run |=> !state.tff;
    endproperty
    a_tff_clear: assert property (p_tff_clear) else $error("toggle flop not cleared");

    property p_tff_flip;
        state.gate_ctrl[TGC_BIT_GTM] && state.run && pol_sig && !state.pol_prev
            && !other_reset ##1 state.gate_ctrl[TGC_BIT_GTM] && state.run
            |-> state.tff != $past(state.tff);
    endproperty
    a_tff_flip: assert property (p_tff_flip) else $error("toggle flop missed edge");

    property p_sp_block;
        state.gate_ctrl[TGC_BIT_SPM] && !state.gate_ctrl[TGC_BIT_GO]
            && !state.capturing |-> !gate_final;
    endproperty
    a_sp_block: assert property (p_sp_block) else $error("unarmed pulse passed");

    sequence s_pulse_end;
        state.capturing && t_fall && !(wr_en && paddr == TGC_OFS_GATE);
    endsequence
    property p_go_done;
        s_pulse_end |=> !state.gate_ctrl[TGC_BIT_GO];
    endproperty
    a_go_done: assert property (p_go_done) else $error("acquire flag not cleared");

    property p_spm_clears_go;
        !state.gate_ctrl[TGC_BIT_SPM] |-> !state.gate_ctrl[TGC_BIT_GO] && !state.capturing;
    endproperty
    a_spm_clears_go: assert property (p_spm_clears_go) else $error("flag left armed");

    property p_event_flag;
        gevt |=> state.status;
    endproperty
    a_event_flag: assert property (p_event_flag) else $error("gate event lost");

    property p_run_off;
        !state.run |-> !count_inc;
    endproperty
    a_run_off: assert property (p_run_off) else $error("count while stopped");

    property p_spm_pass;
        !state.gate_ctrl[TGC_BIT_SPM] |-> gate_final == t_out;
    endproperty
    a_spm_pass: assert property (p_spm_pass) else $error("pulse stage not transparent");

    property p_level_view;
        setup && paddr == TGC_OFS_GATE |=> prdata[TGC_BIT_VAL] == $past(level);
    endproperty
    a_level_view: assert property (p_level_view) else $error("gate level view wrong");

    property p_src_match;
        state.gate_ctrl[TGC_SS_HI:TGC_SS_LO] == TGC_SRC_MATCH |-> src_sig == period_match;
    endproperty
    a_src_match: assert property (p_src_match) else $error("period match not selected");

    property p_src_comp2;
        state.gate_ctrl[TGC_SS_HI:TGC_SS_LO] == TGC_SRC_COMP2 |-> src_sig == comp2_synced_output;
    endproperty
    a_src_comp2: assert property (p_src_comp2) else $error("comparator 2 not selected");

    property p_other_reset;
        other_reset && !(wr_en && paddr == TGC_OFS_GATE)
            |=> !state.run && !state.tff
            && state.gate_ctrl[TGC_BIT_GE:TGC_BIT_SPM]
               == $past(state.gate_ctrl[TGC_BIT_GE:TGC_BIT_SPM]);
    endproperty
    a_other_reset: assert property (p_other_reset) else $error("other reset handling wrong");

    sequence s_pulse_arm;
        sp_start && state.gate_ctrl[TGC_BIT_SPM] && !other_reset;
    endsequence
    property p_pulse_open;
        s_pulse_arm |-> gate_final ##1 (state.capturing || !state.gate_ctrl[TGC_BIT_SPM]);
    endproperty
    a_pulse_open: assert property (p_pulse_open) else $error("armed pulse did not open");

    property p_status_clear;
        wr_en && paddr == TGC_OFS_STATUS && wr_byte[TGC_BIT_GEVT] && !gevt |=> !state.status;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("event flag not cleared");

endmodule : tgc_top

`default_nettype wire

//--- tb/tgc_partner.sv
// partner model: gate pin, period match and comparator sources
`default_nettype none

module tgc_partner (
    input  wire logic       pclk,
    input  wire logic [3:0] want,
    output logic            gate_pin = 1'b0,
    output logic            period_match = 1'b0,
    output logic            comp1_synced_output = 1'b0,
    output logic            comp2_synced_output = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // sources move just after an edge, like any source on the timer clock
    always @(posedge pclk) begin
        {comp2_synced_output, comp1_synced_output, period_match, gate_pin} <= want;
    end
endmodule : tgc_partner

`default_nettype wire

//--- tb/tgc_tb_top.sv
// self-checking bench for the timer gate control block
`default_nettype none

module tgc_tb_top
    import tgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        bit ge, pol, tm, spm, go;
        bit [1:0] src;
        bit run, msk, stat, tff, opn, lvl, adjp, stp;
    } tgc_mdl_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, count_enable, count_inc, irq;
    logic        other_reset = 1'b0, count_tick = 1'b0, g_pin, g_match, g_c1, g_c2;
    logic [3:0]  want = 4'h0, sv = 4'h0;
    logic [31:0] rnd = 32'hB9519959, rv;
    int          num_errors = 0, cmp_count = 0, cyc = 0;
    tgc_mdl_t    m;

    tgc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .other_reset(other_reset), .gate_pin(g_pin),
        .period_match(g_match), .comp1_synced_output(g_c1), .comp2_synced_output(g_c2),
        .count_tick(count_tick), .count_enable(count_enable), .count_inc(count_inc),
        .irq(irq));
    tgc_partner prt (.pclk(pclk), .want(want), .gate_pin(g_pin), .period_match(g_match),
        .comp1_synced_output(g_c1), .comp2_synced_output(g_c2));

    initial forever #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ******************************************************************
    // helpers and reference model
    // ******************************************************************
    function logic [31:0] xorshift();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xorshift

    task tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // gate path: source, polarity, toggle, single pulse
    function void step();
        bit adj, stg, nl;
        adj = (sv[m.src] == m.pol);
        if (!m.tm || !m.run) m.tff = 1'b0;
        else if (adj && !m.adjp) m.tff = ~m.tff;
        stg = m.tm ? m.tff : adj;
        if (!m.spm) {m.go, m.opn} = 2'b00;
        else if (m.go && !m.opn && stg && !m.stp) m.opn = 1'b1;
        else if (m.opn && !stg) {m.go, m.opn} = 2'b00;
        nl = m.spm ? m.opn : stg;
        if (m.lvl && !nl) m.stat = 1'b1;
        m.lvl = nl;
        m.adjp = adj;
        m.stp = stg;
    endfunction : step

    task check_all();
        bit ce;
        repeat (5) @(posedge pclk);
        ce = m.run & (m.ge ? m.lvl : 1'b1);
        rd = xorshift();
        count_tick <= rd[0];
        @(negedge pclk);
        chk("count_enable", count_enable, ce);
        chk("count_inc", count_inc, count_tick & ce);
        @(posedge pclk);
        apb(1'b0, TGC_OFS_GATE, 0);
        chk("gate", rd, {m.ge, m.pol, m.tm, m.spm, m.go, m.lvl, m.src});
        apb(1'b0, TGC_OFS_RUN, 0);
        chk("run", rd, m.run);
        apb(1'b0, TGC_OFS_STATUS, 0);
        chk("status", rd, m.stat);
        chk("irq", irq, m.stat & m.msk);
        apb(1'b1, TGC_OFS_STATUS, 1);
        m.stat = 1'b0;
    endtask : check_all

    task wg(input logic [7:0] v);
        apb(1'b1, TGC_OFS_GATE, {24'h0, v});
        {m.ge, m.pol, m.tm, m.spm, m.go} = v[7:3];
        m.src = v[1:0];
        step();
        check_all();
    endtask : wg

    task ws(input logic [3:0] v);
        want <= v;
        sv = v;
        step();
        check_all();
    endtask : ws

    task wrun(input logic r);
        apb(1'b1, TGC_OFS_RUN, {31'h0, r});
        m.run = r;
        step();
        check_all();
    endtask : wrun

    task do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        m = '0;
        step();
        check_all();
    endtask : do_reset

    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        do_reset();
        apb(1'b0, 12'h010, 0);
        chk("unmapped_err", er, 1);
        chk("unmapped_data", rd, 0);
        chk("pready", pready, 1);
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        apb(1'b1, TGC_OFS_MASK, 1);
        m.msk = 1'b1;
        apb(1'b0, TGC_OFS_MASK, 0);
        chk("mask", rd, m.msk);
        wrun(1'b1);
        repeat (24) begin
            rv = xorshift();
            wg({rv[7:6], 3'b000, rv[2:0]});
            ws(rv[11:8]);
        end
        wg(8'hE0);
        repeat (3) begin
            ws(4'h1);
            ws(4'h0);
        end
        wrun(1'b0);
        wrun(1'b1);
        wg(8'h00);
        wg(8'hD0);
        wg(8'hD8);
        ws(4'h1);
        ws(4'h0);
        ws(4'h1);
        ws(4'h0);
        wg(8'hD8);
        wg(8'hC0);
        wg(8'hA3);
        other_reset <= 1'b1;
        @(posedge pclk);
        other_reset <= 1'b0;
        m.run = 1'b0;
        step();
        check_all();
        do_reset();
        tally_and_finish();
    end
endmodule : tgc_tb_top

`default_nettype wire
